// ==== rtl/fsc_fiber_regs.sv ====
// Our own choice: register access over APB.
module fsc_fiber_regs
    import fsc_pkg::*;
#(
    parameter int SOFT_RST_CYC = FSC_SOFT_RST_CYC
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic strap_negotiation_enable,
    input wire logic [1:0] strap_rate_code,
    input wire logic mac_tx_enable,
    input wire logic line_collision,
    input wire logic negotiation_done_in,
    input wire logic far_fault_in,
    input wire logic fx_link_up,
    input wire logic bx_link_up,
    input wire logic serial_link_up,
    input wire logic partner_link_up,
    input wire logic [1:0] negotiated_rate,
    output logic fiber_logic_reset,
    output logic mac_side_loop_enable,
    output logic [1:0] link_rate,
    output logic negotiation_enable,
    output logic negotiation_restart,
    output logic serial_power_down,
    output logic mac_port_isolate,
    output logic forced_duplex,
    output logic collision,
    output logic [2:0] operation_mode_select
);

    localparam int CNT_W = $clog2(SOFT_RST_CYC + 1);
    localparam logic [CNT_W-1:0] RST_LAST = CNT_W'(SOFT_RST_CYC - 1);

    logic [15:0] ctrl_reg;
    logic [15:0] ctrl_next;
    logic [2:0] mode_reg;
    logic [2:0] mode_next;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    fsc_rst_state_t rst_state_reg;
    logic [CNT_W-1:0] rst_cnt_reg;
    logic rst_done;
    logic [1:0] strap_cnt_reg;
    logic strap_loaded_reg;
    logic strap_load;
    logic [2:0] strap_sync;
    logic tx_sync;
    logic [15:0] sts_word;
    logic link_now;
    logic is_bx;
    logic is_fx;
    logic is_p2s;
    logic is_s2p;
    logic is_sgmii;
    logic setup_phase;
    logic access_phase;
    logic hit_ctrl;
    logic hit_sts;
    logic hit_mode;
    logic wr_ctrl;
    logic wr_mode;
    logic [15:0] wr_mask;
    logic [15:0] ctrl_written;
    logic [1:0] rate_code;

    // pins from outside the clock domain
    fsc_sync #(
        .WIDTH(3)
    ) u_strap_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .async_in({strap_negotiation_enable, strap_rate_code}),
        .sync_out(strap_sync)
    );

    fsc_sync #(
        .WIDTH(1)
    ) u_tx_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .async_in(mac_tx_enable),
        .sync_out(tx_sync)
    );

    // mode decode shared by every mode-dependent control but forced duplex
    always_comb begin
        is_bx = (mode_reg == FSC_MODE_PAR_BX) || (mode_reg == FSC_MODE_MC_BX); // [RULE20]
        is_fx = (mode_reg == FSC_MODE_PAR_FX) || (mode_reg == FSC_MODE_MC_FX); // [RULE20]
        is_p2s = (mode_reg == FSC_MODE_PAR_SGMII); // [RULE20]
        is_s2p = (mode_reg == FSC_MODE_SGMII_COPPER); // [RULE20]
        is_sgmii = is_p2s || is_s2p;
    end

    // apb decode; the one register set is shared by all fiber and bridge modes
    always_comb begin
        setup_phase = psel && !penable;
        access_phase = psel && penable;
        hit_ctrl = (paddr == FSC_CTRL_ADDR); // [RULE19]
        hit_sts = (paddr == FSC_STS_ADDR);
        hit_mode = (paddr == FSC_MODE_ADDR);
        wr_ctrl = access_phase && pwrite && hit_ctrl;
        wr_mode = access_phase && pwrite && hit_mode;
        wr_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    end

    // straps are caught a few cycles after release, once the synchroniser has filled
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            strap_cnt_reg <= 2'h0;
            strap_loaded_reg <= 1'b0;
        end else begin
            if (!strap_loaded_reg) begin
                strap_cnt_reg <= strap_cnt_reg + 2'h1;
            end
            if (strap_load) begin
                strap_loaded_reg <= 1'b1;
            end
        end
    end

    assign strap_load = !strap_loaded_reg && (strap_cnt_reg == FSC_STRAP_SETTLE_CYC);

    // soft reset sequencer
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_state_reg <= FSC_RST_IDLE;
            rst_cnt_reg <= '0;
        end else begin
            unique case (rst_state_reg)
                FSC_RST_IDLE: begin
                    if (ctrl_reg[FSC_C_SOFT_RESET]) begin
                        rst_state_reg <= FSC_RST_HOLD; // [RULE1]
                        rst_cnt_reg <= '0;
                    end
                end
                FSC_RST_HOLD: begin
                    if (rst_cnt_reg == RST_LAST) begin
                        rst_state_reg <= FSC_RST_IDLE; // [RULE1]
                    end else begin
                        rst_cnt_reg <= rst_cnt_reg + CNT_W'(1);
                    end
                end
            endcase
        end
    end

    assign rst_done = (rst_state_reg == FSC_RST_HOLD) && (rst_cnt_reg == RST_LAST);

    // control word next value: hardware effects, then the write merged by byte lanes on top
    always_comb begin
        ctrl_written = (ctrl_reg & ~wr_mask) | (pwdata[15:0] & wr_mask);
        ctrl_next = ctrl_reg;
        if (strap_load) begin
            ctrl_next[FSC_C_NEG_EN] = strap_sync[2]; // [RULE5]
            ctrl_next[FSC_C_RATE_HIGH] = strap_sync[1]; // [RULE3]
            ctrl_next[FSC_C_RATE_LOW] = strap_sync[0]; // [RULE3]
        end
        // self-clearing bits drop unless the same cycle writes them again
        if (rst_done) begin
            ctrl_next[FSC_C_SOFT_RESET] = 1'b0; // [RULE1]
        end
        if (ctrl_reg[FSC_C_RESTART]) begin
            ctrl_next[FSC_C_RESTART] = 1'b0; // [RULE8]
        end
        if (wr_ctrl) begin
            ctrl_next = ctrl_written;
            // a busy soft reset is not cleared by a write of zero
            if (rst_state_reg == FSC_RST_HOLD && !rst_done) begin
                ctrl_next[FSC_C_SOFT_RESET] = ctrl_reg[FSC_C_SOFT_RESET];
            end
        end
    end

    always_comb begin
        mode_next = mode_reg;
        if (wr_mode && pstrb[0]) begin
            mode_next = pwdata[2:0]; // [RULE20]
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= FSC_CTRL_RESET; // [RULE5] [RULE9]
            mode_reg <= FSC_MODE_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
            mode_reg <= mode_next;
        end
    end

    // link indication by mode
    always_comb begin
        link_now = 1'b0;
        if (is_fx) begin
            link_now = fx_link_up; // [RULE15]
        end else if (is_bx) begin
            link_now = bx_link_up; // [RULE15]
        end else if (is_p2s) begin
            if (ctrl_reg[FSC_C_NEG_EN]) begin
                link_now = serial_link_up && partner_link_up; // [RULE16]
            end else begin
                link_now = serial_link_up; // [RULE16]
            end
        end else if (is_s2p) begin
            link_now = partner_link_up; // [RULE17]
        end
    end

    // constant bits give the fixed abilities; live bits from the coding logic
    always_comb begin
        sts_word = FSC_STS_FIXED; // [RULE11] [RULE12] [RULE18]
        sts_word[FSC_S_NEG_DONE] = negotiation_done_in; // [RULE13]
        sts_word[FSC_S_FAR_FAULT] = far_fault_in; // [RULE14]
        sts_word[FSC_S_LINK_UP] = link_now;
    end

    // read data captured in setup so it comes from a flip-flop with zero wait
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (setup_phase) begin
            pslverr_reg <= !(hit_ctrl || hit_sts || hit_mode);
            if (pwrite) begin
                prdata_reg <= 32'h0000_0000;
            end else if (hit_ctrl) begin
                prdata_reg <= {16'h0000, ctrl_reg};
            end else if (hit_sts) begin
                prdata_reg <= {16'h0000, sts_word};
            end else if (hit_mode) begin
                prdata_reg <= {29'h0000_0000, mode_reg};
            end else begin
                prdata_reg <= 32'h0000_0000;
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = access_phase && pslverr_reg;

    // effective link rate; in SGMII the negotiated rate wins while negotiating
    always_comb begin
        rate_code = {ctrl_reg[FSC_C_RATE_HIGH], ctrl_reg[FSC_C_RATE_LOW]}; // [RULE3]
        if (is_sgmii && ctrl_reg[FSC_C_NEG_EN]) begin
            rate_code = negotiated_rate; // [RULE4]
        end
    end

    // registered control outputs toward the coding logic
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            fiber_logic_reset <= 1'b1;
            mac_side_loop_enable <= 1'b0;
            link_rate <= 2'h0;
            negotiation_enable <= 1'b0;
            negotiation_restart <= 1'b0;
            serial_power_down <= 1'b0;
            mac_port_isolate <= 1'b0;
            forced_duplex <= 1'b1;
            collision <= 1'b0;
            operation_mode_select <= FSC_MODE_RESET;
        end else begin
            // power-down also keeps the datapath in reset, not the registers
            fiber_logic_reset <= (rst_state_reg == FSC_RST_HOLD) // [RULE1]
                || (ctrl_reg[FSC_C_POWER_DOWN] && (is_bx || is_fx || is_sgmii)); // [RULE6]
            mac_side_loop_enable <= ctrl_reg[FSC_C_LOOP]
                && (is_bx || is_fx || is_sgmii); // [RULE2]
            link_rate <= rate_code;
            negotiation_enable <= ctrl_reg[FSC_C_NEG_EN] && (is_bx || is_sgmii); // [RULE5]
            negotiation_restart <= ctrl_reg[FSC_C_RESTART] && (is_bx || is_sgmii); // [RULE8]
            serial_power_down <= ctrl_reg[FSC_C_POWER_DOWN]
                && (is_bx || is_fx || is_sgmii); // [RULE6]
            mac_port_isolate <= ctrl_reg[FSC_C_ISOLATE] && (is_bx || is_fx || is_p2s); // [RULE7]
            // outside the MII-to-FX mode the duplex stays full
            if (mode_reg == FSC_MODE_PAR_FX) begin
                forced_duplex <= ctrl_reg[FSC_C_DUPLEX]; // [RULE9]
            end else begin
                forced_duplex <= 1'b1;
            end
            if (ctrl_reg[FSC_C_COL_TEST]) begin
                collision <= tx_sync; // [RULE10]
            end else begin
                collision <= line_collision;
            end
            operation_mode_select <= mode_reg; // [RULE20]
        end
    end

endmodule

// ==== rtl/fsc_pkg.sv ====
// How it works
// RULE1 - setting the soft reset bit resets fiber logic, bit self-clears when done
// RULE2 - loopback bit loops MAC data back in FX, BX and both bridge modes
// RULE3 - two-bit rate code, low bit 13, high bit 6; straps load it
// RULE4 - in SGMII modes the rate code forces speed only with negotiation off
// RULE5 - negotiation enable bit acts in BX and bridge modes; strap loads it, resets 1
// RULE6 - power-down bit powers serial side down and holds fiber logic in reset; the code does so only in FX, BX and both bridge modes
// RULE7 - isolate bit isolates MAC port in BX, FX, parallel-to-serial bridge only
// RULE8 - writing restart bit restarts negotiation in SGMII and BX; hardware clears it
// RULE9 - forced duplex bit selects half or full, only in MII-to-FX mode
// RULE10 - collision self test asserts collision whenever transmit enable is high
// RULE11 - status reads 1 in FX duplex abilities, 0 in T4, 10M, T2 bits
// RULE12 - status reads 1 in extended status, short preamble, extended capability bits
// RULE13 - negotiation done bit reads 1 once negotiation has finished
// RULE14 - far fault bit reads 1 when a remote fault has been detected
// RULE15 - link bit shows FX link in FX modes, BX link in BX modes
// RULE16 - parallel-to-serial bridge link needs serial and partner link when negotiating
// RULE17 - serial-to-parallel bridge link bit shows the partner link
// RULE18 - negotiation capable reads 1, jabber flag reads 0
// RULE19 - one register space serves fiber, both bridges and media converters
// RULE20 - three-bit operation mode field selects the operating mode
package fsc_pkg;

    // register indices; byte address is four times the index
    localparam logic [11:0] FSC_CTRL_IDX = 12'h0c00;
    localparam logic [11:0] FSC_STS_IDX = 12'h0c01;
    localparam logic [11:0] FSC_MODE_IDX = 12'h0c1f;
    localparam logic [15:0] FSC_CTRL_ADDR = {2'b00, FSC_CTRL_IDX, 2'b00};
    localparam logic [15:0] FSC_STS_ADDR = {2'b00, FSC_STS_IDX, 2'b00};
    localparam logic [15:0] FSC_MODE_ADDR = {2'b00, FSC_MODE_IDX, 2'b00};

    localparam logic [15:0] FSC_CTRL_RESET = 16'h1140;
    localparam logic [15:0] FSC_STS_RESET = 16'h6149;
    // constant ones of the status word
    localparam logic [15:0] FSC_STS_FIXED = 16'h6149;
    localparam logic [2:0] FSC_MODE_RESET = 3'h0;

    // control field positions
    localparam int FSC_C_SOFT_RESET = 15;
    localparam int FSC_C_LOOP = 14;
    localparam int FSC_C_RATE_LOW = 13;
    localparam int FSC_C_NEG_EN = 12;
    localparam int FSC_C_POWER_DOWN = 11;
    localparam int FSC_C_ISOLATE = 10;
    localparam int FSC_C_RESTART = 9;
    localparam int FSC_C_DUPLEX = 8;
    localparam int FSC_C_COL_TEST = 7;
    localparam int FSC_C_RATE_HIGH = 6;

    // status field positions
    localparam int FSC_S_NEG_DONE = 5;
    localparam int FSC_S_FAR_FAULT = 4;
    localparam int FSC_S_LINK_UP = 2;

    // operation mode codes
    localparam logic [2:0] FSC_MODE_PAR_COPPER = 3'h0;
    localparam logic [2:0] FSC_MODE_PAR_BX = 3'h1;
    localparam logic [2:0] FSC_MODE_PAR_FX = 3'h2;
    localparam logic [2:0] FSC_MODE_PAR_SGMII = 3'h3;
    localparam logic [2:0] FSC_MODE_MC_BX = 3'h4;
    localparam logic [2:0] FSC_MODE_MC_FX = 3'h5;
    localparam logic [2:0] FSC_MODE_SGMII_COPPER = 3'h6;
    localparam logic [2:0] FSC_MODE_RESERVED = 3'h7;

    // timing
    localparam int FSC_CLK_MHZ = 125;
    localparam int FSC_SOFT_RST_NS = 128;
    localparam int FSC_SOFT_RST_CYC = (FSC_SOFT_RST_NS * FSC_CLK_MHZ + 999) / 1000;
    localparam int FSC_SYNC_STAGES = 2;
    localparam logic [1:0] FSC_STRAP_SETTLE_CYC = 2'h3;

    typedef enum logic [0:0] {
        FSC_RST_IDLE,
        FSC_RST_HOLD
    } fsc_rst_state_t;

endpackage

// ==== rtl/fsc_sync.sv ====
module fsc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // first stage feeds the second stage only
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;

endmodule

// ==== sim/fsc_fiber_regs_monitor.sv ====
module fsc_fiber_regs_monitor
    import fsc_pkg::*;
#(
    parameter int SOFT_RST_CYC = FSC_SOFT_RST_CYC
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic negotiation_done_in,
    input wire logic far_fault_in,
    input wire logic fx_link_up,
    input wire logic bx_link_up,
    input wire logic serial_link_up,
    input wire logic partner_link_up,
    input wire logic [1:0] negotiated_rate,
    input wire logic fiber_logic_reset,
    input wire logic [1:0] link_rate,
    input wire logic negotiation_enable,
    input wire logic negotiation_restart,
    input wire logic serial_power_down,
    input wire logic mac_port_isolate,
    input wire logic forced_duplex,
    input wire logic [2:0] operation_mode_select
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic sts_rd;
    logic link_exp;
    int rst_run;
    assign sts_rd = psel && penable && !pwrite && paddr == FSC_STS_ADDR;
    always_comb begin
        case (operation_mode_select)
            3'h1, 3'h4: link_exp = bx_link_up;
            3'h2, 3'h5: link_exp = fx_link_up;
            3'h3: link_exp = negotiation_enable ? serial_link_up && partner_link_up
                : serial_link_up;
            default: link_exp = partner_link_up;
        endcase
    end
    // power-down holds reset indefinitely, so only soft reset runs are counted
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_run <= 0;
        end else if (fiber_logic_reset && !serial_power_down) begin
            rst_run <= rst_run + 1;
        end else begin
            rst_run <= 0;
        end
    end
    property p_sts_fixed;
        sts_rd |-> (prdata[15:0] & 16'hffcb) == 16'h6149 && prdata[31:16] == 16'h0000;
    endproperty
    a_sts_fixed: assert property (p_sts_fixed)
        else $error("status constant bits wrong");
    property p_sts_live;
        sts_rd |-> prdata[5] == $past(negotiation_done_in) && prdata[4] == $past(far_fault_in);
    endproperty
    a_sts_live: assert property (p_sts_live)
        else $error("status done or fault bit wrong");
    property p_link;
        sts_rd && $past(operation_mode_select) inside {[3'h1:3'h6]}
            |-> prdata[2] == $past(link_exp);
    endproperty
    a_link: assert property (p_link)
        else $error("link bit wrong for mode");
    property p_restart_pulse;
        negotiation_restart |=> !negotiation_restart;
    endproperty
    a_restart_pulse: assert property (p_restart_pulse)
        else $error("restart pulse too long");
    property p_restart_mode;
        negotiation_restart |-> operation_mode_select inside {3'h1, 3'h3, 3'h4, 3'h6};
    endproperty
    a_restart_mode: assert property (p_restart_mode)
        else $error("restart in wrong mode");
    property p_isolate;
        mac_port_isolate |-> operation_mode_select inside {[3'h1:3'h5]};
    endproperty
    a_isolate: assert property (p_isolate) else $error("isolate in wrong mode");
    property p_duplex;
        operation_mode_select != FSC_MODE_PAR_FX |-> forced_duplex;
    endproperty
    a_duplex: assert property (p_duplex) else $error("half duplex outside fx mode");
    property p_pdown;
        serial_power_down |-> fiber_logic_reset;
    endproperty
    a_pdown: assert property (p_pdown) else $error("power down without logic reset");
    property p_rate;
        operation_mode_select inside {3'h3, 3'h6} && negotiation_enable
            && $stable(negotiation_enable) && $stable(operation_mode_select)
            |-> link_rate == $past(negotiated_rate);
    endproperty
    a_rate: assert property (p_rate) else $error("rate forced while negotiating");
    property p_soft_len;
        rst_run <= SOFT_RST_CYC;
    endproperty
    a_soft_len: assert property (p_soft_len) else $error("soft reset held too long");
    c_restart: cover property (negotiation_restart);
    c_soft: cover property ($rose(fiber_logic_reset));
    c_err: cover property (pslverr);
endmodule

// ==== sim/fsc_far_end.sv ====
module fsc_far_end #(
    parameter int AN_CYC = 40
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic negotiation_restart,
    input wire logic serial_power_down,
    input wire logic [7:0] env,
    output logic negotiation_done_in,
    output logic far_fault_in,
    output logic fx_link_up,
    output logic bx_link_up,
    output logic serial_link_up,
    output logic partner_link_up,
    output logic [1:0] negotiated_rate,
    output logic line_collision
);
    timeunit 1ns;
    timeprecision 1ps;
    int an_cnt;
    // negotiation reruns from scratch on each restart pulse
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            an_cnt <= 0;
        end else if (negotiation_restart) begin
            an_cnt <= 0;
        end else if (an_cnt < AN_CYC) begin
            an_cnt <= an_cnt + 1;
        end
    end
    assign negotiation_done_in = an_cnt == AN_CYC;
    assign serial_link_up = env[2] && !serial_power_down;
    assign {line_collision, negotiated_rate, far_fault_in, partner_link_up} = env[7:3];
    assign bx_link_up = env[1];
    assign fx_link_up = env[0];
endmodule

// ==== sim/tb_fsc_fiber_regs.sv ====
module tb_fsc_fiber_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import fsc_pkg::*;
    localparam int SRC = 4;
    logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, sneg, tx_en;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0] srate, nrate, lrate;
    logic [7:0] env;
    logic done, fault, fxl, bxl, serl, parl, lcol, flr, loop, neg, rst, pdn, iso, dup, col;
    logic [2:0] mode;
    logic [32:0] exp_q[$];
    logic [32:0] note;
    int miscompares, samples_checked, restarts, frc, n0;
    logic [2:0] tm[6] = '{3'h1, 3'h0, 3'h3, 3'h6, 3'h2, 3'h1};
    logic [15:0] tc[6] = '{16'h5140, 16'h5140, 16'h1540, 16'h1540, 16'h1040, 16'h1040};
    logic [2:0] te[6] = '{3'h5, 3'h1, 3'h3, 3'h1, 3'h0, 3'h1};
    fsc_fiber_regs #(.SOFT_RST_CYC(SRC)) u_fsc_fiber_regs (.mclk(mclk), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .strap_negotiation_enable(sneg), .strap_rate_code(srate), .mac_tx_enable(tx_en),
        .line_collision(lcol), .negotiation_done_in(done), .far_fault_in(fault),
        .fx_link_up(fxl), .bx_link_up(bxl), .serial_link_up(serl), .partner_link_up(parl),
        .negotiated_rate(nrate), .fiber_logic_reset(flr), .mac_side_loop_enable(loop),
        .link_rate(lrate), .negotiation_enable(neg), .negotiation_restart(rst),
        .serial_power_down(pdn), .mac_port_isolate(iso), .forced_duplex(dup),
        .collision(col), .operation_mode_select(mode));
    fsc_far_end #(.AN_CYC(40)) u_fsc_far_end (.mclk(mclk), .reset_n(reset_n),
        .negotiation_restart(rst), .serial_power_down(pdn), .env(env),
        .negotiation_done_in(done), .far_fault_in(fault), .fx_link_up(fxl), .bx_link_up(bxl),
        .serial_link_up(serl), .partner_link_up(parl), .negotiated_rate(nrate),
        .line_collision(lcol));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic close_out();
        $display("checked %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic [15:0] a, input logic w, input logic [15:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= {16'h0000, d};
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic [15:0] mk,
                      input logic err);
        exp_q.push_back({err, mk, e});
        apb(a, 1'b0, 16'h0000);
    endtask
    task automatic cfg(input logic [2:0] m, input logic [15:0] c);
        apb(FSC_MODE_ADDR, 1'b1, {13'h0000, m});
        apb(FSC_CTRL_ADDR, 1'b1, c);
        repeat (3) @(posedge mclk);
    endtask
    function automatic logic lnk(int m, int a);
        case (m)
            1, 4: return env[1];
            2, 5: return env[0];
            3: return a ? env[2] && env[3] : env[2];
            default: return env[3];
        endcase
    endfunction
    // read data sampled mid access cycle, clear of the capture edges
    always @(negedge mclk) begin
        if (psel && penable && !pwrite) begin
            note = exp_q.pop_front();
            chk("prdata", {note[32], 16'h0000, note[15:0]},
                {pslverr, prdata[31:16], prdata[15:0] & note[31:16]});
        end
    end
    always @(posedge mclk) begin
        if (rst === 1'b1) restarts++;
        if (flr === 1'b1) frc++;
    end
    initial begin
        #200000;
        miscompares++;
        close_out();
    end
    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata, tx_en, env} = '0;
        sneg = 1'b1;
        srate = 2'b10;
        void'($urandom(32'h6708));
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (50) @(posedge mclk);
        rd(FSC_CTRL_ADDR, 16'h1140, 16'hffff, 1'b0);
        rd(FSC_STS_ADDR, 16'h6169, 16'hfffb, 1'b0);
        rd(16'h3008, 16'h0000, 16'hffff, 1'b1);
        for (int m = 1; m < 7; m++) begin
            for (int a = 0; a < 2; a++) begin
                env <= 8'($urandom);
                cfg(3'(m), a ? 16'h1140 : 16'h0140);
                chk("neg_en", 33'(a && m inside {1, 3, 4, 6}), 33'(neg));
                chk("mode", 33'(m), 33'(mode));
                chk("rate", a && m inside {3, 6} ? 33'(env[6:5]) : 33'd2, 33'(lrate));
                rd(FSC_STS_ADDR, {10'h185, 1'b1, env[4], 1'b1, lnk(m, a), 2'b01}, 16'hffff,
                   1'b0);
            end
        end
        cfg(3'h1, 16'h1140);
        n0 = restarts;
        apb(FSC_CTRL_ADDR, 1'b1, 16'h1340);
        rd(FSC_CTRL_ADDR, 16'h1140, 16'hffff, 1'b0);
        rd(FSC_STS_ADDR, 16'h0000, 16'h0020, 1'b0);
        chk("restarts", 33'(n0 + 1), 33'(restarts));
        cfg(3'h2, 16'h1340);
        chk("restarts", 33'(n0 + 1), 33'(restarts));
        cfg(3'h1, 16'h1140);
        frc = 0;
        apb(FSC_CTRL_ADDR, 1'b1, 16'h9140);
        rd(FSC_CTRL_ADDR, 16'h9140, 16'hffff, 1'b0);
        repeat (10) @(posedge mclk);
        rd(FSC_CTRL_ADDR, 16'h1140, 16'hffff, 1'b0);
        chk("hold", 33'(SRC), 33'(frc));
        cfg(3'h1, 16'h1940);
        chk("pdown", 33'h3, {31'h0, flr, pdn});
        cfg(3'h0, 16'h1940);
        chk("pdown", 33'h0, {31'h0, flr, pdn});
        for (int i = 0; i < 6; i++) begin
            cfg(tm[i], tc[i]);
            chk("loop_iso_dup", 33'(te[i]), {30'h0, loop, iso, dup});
        end
        cfg(3'h1, 16'h11c0);
        tx_en <= 1'b1;
        repeat (4) @(posedge mclk);
        chk("collision", 33'h1, 33'(col));
        tx_en <= 1'b0;
        repeat (4) @(posedge mclk);
        chk("collision", 33'h0, 33'(col));
        close_out();
    end
endmodule
bind fsc_fiber_regs fsc_fiber_regs_monitor #(.SOFT_RST_CYC(SOFT_RST_CYC)) u_mon (.mclk(mclk),
    .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pslverr(pslverr), .negotiation_done_in(negotiation_done_in),
    .far_fault_in(far_fault_in), .fx_link_up(fx_link_up), .bx_link_up(bx_link_up),
    .serial_link_up(serial_link_up), .partner_link_up(partner_link_up),
    .negotiated_rate(negotiated_rate), .fiber_logic_reset(fiber_logic_reset),
    .link_rate(link_rate), .negotiation_enable(negotiation_enable),
    .negotiation_restart(negotiation_restart), .serial_power_down(serial_power_down),
    .mac_port_isolate(mac_port_isolate), .forced_duplex(forced_duplex),
    .operation_mode_select(operation_mode_select));
